// ==== logic/copro_pkg.sv ====
// constants and types shared by the transfer coprocessor control block
package copro_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL  = 8'h1c;
	localparam logic [7:0] IDX_STATUS   = 8'h1d;
	localparam logic [7:0] IDX_POINTER  = 8'h1f;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
	localparam logic [7:0] IDX_RAM_ADDR = 8'h22;
	localparam logic [7:0] IDX_RAM_DATA = 8'h23;
	localparam logic [7:0] IDX_ARB      = 8'h24;

	// control fields
	localparam int CTL_RUN    = 0;
	localparam int CTL_INIT   = 1;
	localparam int CTL_LOAD   = 2;
	localparam int CTL_STOP_IRQ_ENABLE = 3;
	localparam int CTL_ERROR_IRQ_ENABLE  = 4;

	// status and interrupt fields
	localparam int STS_STOP  = 0;
	localparam int STS_ERROR = 1;
	localparam int NUM_EVT   = 2;

	// requestor positions, highest priority lowest
	localparam int REQ_CORE  = 0;
	localparam int REQ_USB   = 1;
	localparam int REQ_COPRO = 2;
	localparam int NUM_REQ   = 3;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

	typedef struct packed {
		logic err_en;
		logic stop_en;
		logic load;
		logic init;
		logic run;
	} control_s;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] index;
	} bus_req_s;
endpackage

// ==== logic/transfer_coprocessor_control.sv ====
// control, program store, interrupt and buffer arbitration for the transfer coprocessor
//
// Function
// RULE1: shared buffer held by one requestor; others wait until it is released
// RULE2: no time limit on how long a granted requestor holds the buffer
// RULE3: free buffer goes by fixed priority: core, then USB, then coprocessor
// RULE4: program RAM writes accepted only while load-enable (control bit 2) is one
// RULE5: load-enable can only be set while run is zero
// RULE6: run (control bit 0) settable only while load-enable zero; one starts, zero stops
// RULE7: hardware clears run whenever the stop flag becomes one
// RULE8: while init (control bit 1) is one, pointer is copied to program position
// RULE9: eight-bit write-only pointer register holds the function entry address
// RULE10: init while running repositions on the fly, after any internal interrupt routine
// RULE11: software stops, sets load-enable, writes up to 256 bytes, clears load-enable
// RULE12: software stops, writes pointer, pulses init, then sets run
// RULE13: error flag (status bit 1) set on error while running; status read clears
// RULE14: stop flag (status bit 0) set when coprocessor terminates; status read clears
// RULE15: error and stop share one interrupt, each gated by control bits 4 and 3
// RULE16: control, status and pointer registers reset to zero
// RULE17: status bits 7 to 2 read zero; control bits 7 to 5 stay zero
// RULE18: assigned port pins take coprocessor alternate functions once loaded and started
// RULE19: core should avoid the buffer while USB and coprocessor exchange data
`timescale 1ns/100ps
`default_nettype none
module transfer_coprocessor_control #(
	parameter int RAM_DEPTH = 256,
	parameter int AW        = 8
) (
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	// ahb-lite slave
	input  wire logic                         hsel_i,
	input  wire logic [31:0]                  haddr_i,
	input  wire logic [1:0]                   htrans_i,
	input  wire logic                         hwrite_i,
	input  wire logic [2:0]                   hsize_i,
	input  wire logic [31:0]                  hwdata_i,
	input  wire logic                         hready_i,
	output logic      [31:0]                  hrdata_o,
	output logic                              hreadyout_o,
	output logic                              hresp_o,
	// coprocessor engine
	input  wire logic [AW-1:0]                fetch_addr_i,
	output logic      [7:0]                   fetch_data_o,
	input  wire logic                         copro_stop_i,
	input  wire logic                         copro_error_i,
	input  wire logic                         copro_in_isr_i,
	output logic                              copro_run_o,
	output logic                              position_load_o,
	output logic      [7:0]                   entry_address_o,
	output logic                              port_alt_sel_o,
	// shared buffer arbitration
	input  wire logic [copro_pkg::NUM_REQ-1:0] buf_req_i,
	output logic      [copro_pkg::NUM_REQ-1:0] buf_grant_o,
	// interrupt
	output logic                              irq_o
);
	copro_pkg::control_s                  control_q;
	logic [copro_pkg::NUM_EVT-1:0]        status_q;
	logic [7:0]                           entry_pointer_q;
	logic [copro_pkg::NUM_EVT-1:0]        irq_stat_q;
	logic [copro_pkg::NUM_EVT-1:0]        irq_mask_q;
	logic [AW-1:0]                        ram_addr_q;
	logic [7:0]                           ram_q [RAM_DEPTH];
	logic                                 loaded_q;
	logic                                 wrote_q;
	copro_pkg::bus_req_s                  req_q;
	logic                                 hready_q;
	logic [31:0]                          hrdata_q;
	logic [copro_pkg::NUM_REQ-1:0]        grant_q;
	logic                                 irq_q;
	logic                                 pos_load_q;

	logic                                 take;
	logic                                 do_wr;
	logic                                 do_rd;
	logic [copro_pkg::NUM_EVT-1:0]        evt;
	logic [copro_pkg::NUM_EVT-1:0]        status_rd_clr;
	logic [copro_pkg::NUM_EVT-1:0]        irq_w1c;
	logic [copro_pkg::NUM_EVT-1:0]        irq_en;
	logic [31:0]                          rd_mux;

	// bus: one wait state per transfer, the work is done in the data phase
	assign take  = hsel_i && htrans_i[1] && hready_i;
	assign do_wr = req_q.valid && req_q.write;
	assign do_rd = req_q.valid && !req_q.write;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			req_q    <= '0;
			hready_q <= 1'b1;
		end else if (take) begin
			req_q    <= '{valid: 1'b1, write: hwrite_i, index: haddr_i[9:2]};
			hready_q <= 1'b0;
		end else begin
			req_q    <= '0;
			hready_q <= 1'b1;
		end
	end

	// read data; unmapped and write-only locations read zero
	always_comb begin
		rd_mux = copro_pkg::RST_WORD;
		case (req_q.index)
			copro_pkg::IDX_CONTROL:  rd_mux[4:0] = control_q;          // [RULE17]
			copro_pkg::IDX_STATUS:   rd_mux[1:0] = status_q;           // [RULE17]
			copro_pkg::IDX_IRQ_STAT: rd_mux[1:0] = irq_stat_q;
			copro_pkg::IDX_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
			copro_pkg::IDX_RAM_ADDR: rd_mux[AW-1:0] = ram_addr_q;
			copro_pkg::IDX_RAM_DATA: rd_mux[7:0] = ram_q[ram_addr_q];
			copro_pkg::IDX_ARB:      rd_mux[2:0] = grant_q;
			default:                 rd_mux = copro_pkg::RST_WORD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hrdata_q <= copro_pkg::RST_WORD;
		end else if (do_rd) begin
			hrdata_q <= rd_mux;
		end
	end

	// control register with interlocks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			control_q <= '0;                                            // [RULE16]
		end else begin
			if (do_wr && req_q.index == copro_pkg::IDX_CONTROL) begin
				control_q.err_en  <= hwdata_i[copro_pkg::CTL_ERROR_IRQ_ENABLE];
				control_q.stop_en <= hwdata_i[copro_pkg::CTL_STOP_IRQ_ENABLE];
				control_q.init    <= hwdata_i[copro_pkg::CTL_INIT];
				control_q.load    <= hwdata_i[copro_pkg::CTL_LOAD]
					&& (control_q.load || !control_q.run);              // [RULE5]
				control_q.run     <= hwdata_i[copro_pkg::CTL_RUN]
					&& (control_q.run || !control_q.load);              // [RULE6]
			end
			if (evt[copro_pkg::STS_STOP]) begin
				control_q.run <= 1'b0;                                  // [RULE7]
			end
		end
	end

	// entry pointer, write only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			entry_pointer_q <= copro_pkg::RST_BYTE;                    // [RULE16]
		end else if (do_wr && req_q.index == copro_pkg::IDX_POINTER) begin
			entry_pointer_q <= hwdata_i[7:0];                          // [RULE9]
		end
	end

	// program position copy; held off while an internal routine runs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pos_load_q <= 1'b0;
		end else begin
			pos_load_q <= control_q.init
				&& !(control_q.run && copro_in_isr_i);                 // [RULE8] [RULE10]
		end
	end

	// program ram, write protected
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ram_addr_q <= '0;
		end else if (do_wr && req_q.index == copro_pkg::IDX_RAM_ADDR) begin
			ram_addr_q <= hwdata_i[AW-1:0];
		end else if (do_wr && req_q.index == copro_pkg::IDX_RAM_DATA && control_q.load) begin
			ram_addr_q <= ram_addr_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_wr && req_q.index == copro_pkg::IDX_RAM_DATA && control_q.load) begin
			ram_q[ram_addr_q] <= hwdata_i[7:0];                        // [RULE4]
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fetch_data_o <= copro_pkg::RST_BYTE;
		end else begin
			fetch_data_o <= ram_q[fetch_addr_i];
		end
	end

	// code counts as loaded once written under load-enable and protection restored
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wrote_q  <= 1'b0;
			loaded_q <= 1'b0;
		end else if (control_q.load) begin
			wrote_q  <= wrote_q
				|| (do_wr && req_q.index == copro_pkg::IDX_RAM_DATA);  // [RULE11]
			loaded_q <= 1'b0;
		end else begin
			wrote_q  <= 1'b0;
			loaded_q <= loaded_q || wrote_q;
		end
	end

	// events and flags
	assign evt[copro_pkg::STS_STOP]  = copro_stop_i;                  // [RULE14]
	assign evt[copro_pkg::STS_ERROR] = copro_error_i && control_q.run; // [RULE13]
	assign irq_en = {control_q.err_en, control_q.stop_en};            // [RULE15]

	generate
		for (genvar i = 0; i < copro_pkg::NUM_EVT; i++) begin : g_evt
			assign status_rd_clr[i] = do_rd && req_q.index == copro_pkg::IDX_STATUS;
			assign irq_w1c[i] = do_wr && req_q.index == copro_pkg::IDX_IRQ_STAT
				&& hwdata_i[i];

			// set wins over the clear by status read
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					status_q[i] <= 1'b0;                               // [RULE16]
				end else if (evt[i]) begin
					status_q[i] <= 1'b1;                               // [RULE13] [RULE14]
				end else if (status_rd_clr[i]) begin
					status_q[i] <= 1'b0;
				end
			end

			// sticky interrupt bit, set wins over write-one-to-clear
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					irq_stat_q[i] <= 1'b0;
				end else if (evt[i] && irq_en[i]) begin
					irq_stat_q[i] <= 1'b1;                             // [RULE15]
				end else if (irq_w1c[i]) begin
					irq_stat_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_mask_q <= '0;
		end else if (do_wr && req_q.index == copro_pkg::IDX_IRQ_MASK) begin
			irq_mask_q <= hwdata_i[copro_pkg::NUM_EVT-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);                       // [RULE15]
		end
	end

	// shared buffer arbiter; holder keeps it as long as it requests
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			grant_q <= '0;
		end else if (|(grant_q & buf_req_i)) begin
			grant_q <= grant_q;                                        // [RULE1] [RULE2]
		end else if (buf_req_i[copro_pkg::REQ_CORE]) begin
			grant_q <= 3'h1;                                           // [RULE3]
		end else if (buf_req_i[copro_pkg::REQ_USB]) begin
			grant_q <= 3'h2;                                           // [RULE3]
		end else if (buf_req_i[copro_pkg::REQ_COPRO]) begin
			grant_q <= 3'h4;                                           // [RULE3]
		end else begin
			grant_q <= '0;
		end
	end

	// alternate function select
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			port_alt_sel_o <= 1'b0;
		end else begin
			port_alt_sel_o <= loaded_q && control_q.run;               // [RULE18]
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hresp_o <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
		end
	end

	assign hrdata_o        = hrdata_q;
	assign hreadyout_o     = hready_q;
	assign copro_run_o     = control_q.run;
	assign position_load_o = pos_load_q;
	assign entry_address_o = entry_pointer_q;
	assign buf_grant_o     = grant_q;
	assign irq_o           = irq_q;
endmodule
`default_nettype wire

// ==== sim/copro_engine_model.sv ====
// behavioural coprocessor engine stepping through the loaded program
`timescale 1ns/100ps
`default_nettype none
module copro_engine_model (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic       go_i,
	input wire logic       err_cmd_i,
	input wire logic       isr_cmd_i,
	input wire logic       run_i,
	input wire logic       pos_load_i,
	input wire logic [7:0] entry_i,
	input wire logic [7:0] fetch_data_i,
	output logic     [7:0] fetch_addr_o,
	output logic           stop_o,
	output logic           error_o,
	output logic           in_isr_o
);
	logic [7:0] pc_q;
	logic       step_q;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pc_q <= 8'h0;
		end else if (pos_load_i) begin
			pc_q <= entry_i;
		end else if (run_i && go_i) begin
			pc_q <= pc_q + 8'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		step_q <= !sys_rst_i && run_i && go_i;
	end
	assign fetch_addr_o = pc_q;
	assign stop_o = run_i && step_q && fetch_data_i == 8'h0;
	assign error_o = run_i && err_cmd_i;
	assign in_isr_o = isr_cmd_i;
endmodule
`default_nettype wire

// ==== sim/copro_monitor.sv ====
// assertion checker for the transfer coprocessor control block
`timescale 1ns/100ps
`default_nettype none
module copro_monitor (
	input wire logic                           clk_i,
	input wire logic                           sys_rst_i,
	input wire logic                           hsel_i,
	input wire logic [1:0]                     htrans_i,
	input wire logic                           hready_i,
	input wire logic                           hreadyout_o,
	input wire logic                           copro_stop_i,
	input wire logic                           copro_in_isr_i,
	input wire logic                           copro_run_o,
	input wire logic                           position_load_o,
	input wire logic                           port_alt_sel_o,
	input wire logic                           irq_o,
	input wire logic [copro_pkg::NUM_REQ-1:0]  buf_req_i,
	input wire logic [copro_pkg::NUM_REQ-1:0]  buf_grant_o
);
	logic [copro_pkg::NUM_REQ-1:0] low_req;
	assign low_req = buf_req_i & (~buf_req_i + 1'b1);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_grant_single: assert property ($onehot0(buf_grant_o))
		else $error("grant not one-hot");
	a_grant_kept: assert property ((buf_grant_o & buf_req_i) != 0 |=> $stable(buf_grant_o))
		else $error("grant moved while held");
	a_grant_order: assert property (
		(buf_grant_o & buf_req_i) == 0 |=> buf_grant_o == $past(low_req)) else $error("bad grant");
	a_stop_halts: assert property (copro_stop_i |=> !copro_run_o)
		else $error("run kept after stop");
	a_isr_defers: assert property (copro_run_o && copro_in_isr_i |=> !position_load_o)
		else $error("reposition inside routine");
	a_alt_needs_run: assert property (!copro_run_o |=> !port_alt_sel_o)
		else $error("alternate pins without run");
	a_alt_drops: assert property (copro_stop_i |-> ##2 !port_alt_sel_o)
		else $error("alternate pins kept after stop");
	a_bus_wait: assert property (
		hsel_i && htrans_i[1] && hready_i |=> !hreadyout_o ##1 hreadyout_o) else $error("bad wait");
	c_usb_grant: cover property (buf_grant_o == 3'h2);
	c_irq: cover property ($rose(irq_o));
	c_reposition: cover property (copro_run_o && position_load_o);
endmodule
bind transfer_coprocessor_control copro_monitor copro_monitor_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .copro_stop_i(copro_stop_i), .copro_in_isr_i(copro_in_isr_i),
	.copro_run_o(copro_run_o), .position_load_o(position_load_o), .irq_o(irq_o),
	.port_alt_sel_o(port_alt_sel_o), .buf_req_i(buf_req_i), .buf_grant_o(buf_grant_o));
`default_nettype wire

// ==== sim/transfer_coprocessor_control_tb.sv ====
// self-checking testbench for the transfer coprocessor control block
`timescale 1ns/100ps
`default_nettype none
module transfer_coprocessor_control_tb;
	localparam logic [7:0] CTL = copro_pkg::IDX_CONTROL;
	localparam logic [7:0] STS = copro_pkg::IDX_STATUS;
	localparam logic [7:0] IST = copro_pkg::IDX_IRQ_STAT;
	localparam logic [7:0] IMK = copro_pkg::IDX_IRQ_MASK;
	localparam logic [7:0] RA  = copro_pkg::IDX_RAM_ADDR;
	localparam logic [7:0] RD  = copro_pkg::IDX_RAM_DATA;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        rd_pend = 1'b0;
	logic        go = 1'b0;
	logic        err_cmd = 1'b0;
	logic        isr_cmd = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  req = 3'h0;
	logic [31:0] hrdata;
	logic        hrdy, hresp, stop, err, isr, run, posl, alt, irq;
	logic [7:0]  faddr, fdata, entry;
	logic [2:0]  grant;
	logic [31:0] exp_q[$];
	logic [7:0]  prog[7];
	logic [2:0]  s_req[8] = '{3'h4, 3'h7, 3'h3, 3'h6, 3'h4, 3'h5, 3'h1, 3'h0};
	logic [2:0]  s_gnt[8] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h0};
	int          n_fail = 0;
	int          cmp_count = 0;
	always #20 clk_i = ~clk_i;
	transfer_coprocessor_control transfer_coprocessor_control_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .fetch_addr_i(faddr),
		.fetch_data_o(fdata), .copro_stop_i(stop), .copro_error_i(err), .copro_in_isr_i(isr),
		.copro_run_o(run), .position_load_o(posl), .entry_address_o(entry),
		.port_alt_sel_o(alt), .buf_req_i(req), .buf_grant_o(grant), .irq_o(irq));
	copro_engine_model copro_engine_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.go_i(go), .err_cmd_i(err_cmd), .isr_cmd_i(isr_cmd), .run_i(run), .pos_load_i(posl),
		.entry_i(entry), .fetch_data_i(fdata), .fetch_addr_o(faddr), .stop_o(stop),
		.error_o(err), .in_isr_o(isr));
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (hrdy !== 1'b1 && k < 64);
		if (hrdy !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= copro_pkg::HTRANS_NONSEQ_BIT;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_pend <= ~w;
		wait_rdy();
		rd_pend <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, idx, 32'h0);
	endtask
	always @(posedge clk_i) begin
		if (rd_pend && hrdy === 1'b1) begin
			chk(hrdata, exp_q.pop_front());
		end
	end
	initial begin
		logic [7:0] r;
		int k;
		void'($urandom(17));
		tick(16);
		sys_rst_i <= 1'b0;
		tick(1);
		rd(CTL, 32'h0);
		rd(STS, 32'h0);
		rd(copro_pkg::IDX_POINTER, 32'h0);
		rd(8'h30, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		xfer(1'b1, CTL, 32'h4);
		xfer(1'b1, CTL, 32'h5);
		rd(CTL, 32'h4);
		xfer(1'b1, RA, 32'h0);
		for (k = 0; k < 7; k++) begin
			prog[k] = (k == 6) ? 8'h0 : 8'($urandom_range(1, 255));
			xfer(1'b1, RD, {24'h0, prog[k]});
		end
		xfer(1'b1, CTL, 32'h0);
		xfer(1'b1, RA, 32'h1);
		xfer(1'b1, RD, 32'haa);
		xfer(1'b1, RA, 32'h1);
		rd(RD, {24'h0, prog[1]});
		xfer(1'b1, IMK, 32'h3);
		r = 8'($urandom);
		xfer(1'b1, copro_pkg::IDX_POINTER, {24'h0, r});
		xfer(1'b1, CTL, 32'h1a);
		tick(1);
		chk({23'h0, posl, entry}, {23'h0, 1'b1, r});
		xfer(1'b1, copro_pkg::IDX_POINTER, 32'h0);
		xfer(1'b1, CTL, 32'h18);
		xfer(1'b1, CTL, 32'h19);
		tick(2);
		chk({30'h0, run, alt}, 32'h3);
		xfer(1'b1, CTL, 32'hfd);
		rd(CTL, 32'h19);
		isr_cmd <= 1'b1;
		xfer(1'b1, CTL, 32'h1b);
		tick(2);
		chk({31'h0, posl}, 32'h0);
		isr_cmd <= 1'b0;
		tick(2);
		chk({31'h0, posl}, 32'h1);
		xfer(1'b1, CTL, 32'h19);
		err_cmd <= 1'b1;
		tick(1);
		err_cmd <= 1'b0;
		go <= 1'b1;
		k = 0;
		while (run !== 1'b0 && k < 99) begin
			tick(1);
			k++;
		end
		if (run !== 1'b0) begin
			n_fail++;
			tally_and_finish();
		end
		tick(2);
		chk({31'h0, irq}, 32'h1);
		rd(CTL, 32'h18);
		rd(STS, 32'h3);
		rd(STS, 32'h0);
		rd(IST, 32'h3);
		xfer(1'b1, IMK, 32'h0);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, IST, 32'h3);
		xfer(1'b1, IMK, 32'h3);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		for (k = 0; k < 8; k++) begin
			req <= s_req[k];
			tick(4);
			chk({29'h0, grant}, {29'h0, s_gnt[k]});
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
